// ### design/pww_pkg.sv
// constants for the wake status and enable block
// assumes an 8-bit register port at the printed offsets
package pww_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_SRC         = 8;

    // printed register offsets
    localparam logic [7:0]  OFS_MASTER_EN   = 8'h01;
    localparam logic [7:0]  OFS_STATUS_G3   = 8'h04;
    localparam logic [7:0]  OFS_ENABLE_G1   = 8'h05;
    // interrupt status and mask
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h09;

    // reset values, applied only by the standby power reset
    localparam logic [7:0]  RST_STATUS_G3   = 8'h00;
    localparam logic [7:0]  RST_ENABLE_G1   = 8'h00;
    localparam logic        RST_MASTER_EN   = 1'b0;
    localparam logic [2:0]  RST_IRQ_STATUS  = 3'h0;
    localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;
    localparam logic [7:0]  RD_ZERO         = 8'h00;

    // field positions
    localparam int          MASTER_EN_BIT   = 0;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_WAKE_RISE   = 0;
    localparam int          IRQ_NEW_LATCH   = 1;
    localparam int          IRQ_BAD_ADDR    = 2;

endpackage

// ### design/pww_evt_if.sv
// carrier between the main block and its edge detector
// assumes both ends share clk_sys_in
`timescale 1ns/1ps
`default_nettype none
interface pww_evt_if #(
    parameter int N = 8
);
    logic [N-1:0] level;
    logic [N-1:0] pulse;

    modport det (
        input  level,
        output pulse
    );
    modport user (
        output level,
        input  pulse
    );
endinterface
`default_nettype wire

// ### design/pww_edge_detect.sv
// rising edge detector for the bank-3 wake inputs
// assumes inputs already synchronous to clk_sys_in
`timescale 1ns/1ps
`default_nettype none
module pww_edge_detect
    import pww_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    pww_evt_if.det    evt
);

    logic [N-1:0] prev_r;

    // a level already high at reset release counts as one event
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_r <= '0;
        end else if (ce_in) begin
            prev_r <= evt.level;
        end
    end

    always_comb begin
        evt.pulse = evt.level & ~prev_r & {N{ce_in}};
    end

endmodule
`default_nettype wire

// ### design/pww_wake_top.sv
// wake status group three, wake enable group one and master enable
// assumes rst_n_in is the standby power reset; main, soft and hard
// resets never reach this block
//
// How it works
// - a rising bank-3 input sets its bit in status group three.
// - status bits latch no matter what any enable bit holds.
// - status group three sits at 04, bit n for bank-3 input n.
// - status survives all resets but the standby one, which zeroes it.
// - writing 1 to a status bit clears it.
// - writing 0 to a status bit leaves it alone.
// - wake request asserts for an enabled, set source under master enable.
// - a disabled source still latches but never drives the wake request.
// - enable group one sits at 05, bit n gating bank-1 input n.
// - enable group one resets to 00 only on the standby reset.
// - master enable, bit 0 at 01, gates the wake request entirely.
`timescale 1ns/1ps
`default_nettype none
module pww_wake_top
    import pww_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    input  wire logic [N-1:0]      gpio_bank3_in,
    input  wire logic [N-1:0]      status_group_one_in,
    input  wire logic [N-1:0]      enable_group_three_in,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic      [N-1:0]      status_group_three_out,
    output logic                   wake_request_out_n,
    output logic                   irq_out
);

    // any enabled bit that is also set
    function automatic logic any_active(
        input logic [N-1:0] stat,
        input logic [N-1:0] en
    );
        any_active = |(stat & en);
    endfunction

    // byte address compare, used by every decode term
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        ofs
    );
        hit = (a == ofs);
    endfunction

    // fit an N-bit field into the data byte
    function automatic logic [DATA_W-1:0] to_byte(
        input logic [N-1:0] v
    );
        logic [DATA_W-1:0] b;
        b = '0;
        b[N-1:0] = v;
        to_byte = b;
    endfunction

    pww_evt_if #(.N(N)) evt ();

    logic [N-1:0]       status_g3_r;
    logic [N-1:0]       status_g3_nxt;
    logic [N-1:0]       enable_g1_r;
    logic               master_en_r;
    logic [IRQ_W-1:0]   irq_status_r;
    logic [IRQ_W-1:0]   irq_status_nxt;
    logic [IRQ_W-1:0]   irq_mask_r;
    logic [IRQ_W-1:0]   irq_event;
    logic [DATA_W-1:0]  rd_data_r;
    logic [DATA_W-1:0]  rd_data_nxt;
    logic               wake_r;
    logic               wake_nxt;
    logic               wr_status_g3;
    logic               wr_enable_g1;
    logic               wr_master;
    logic               wr_irq_mask;
    logic               rd_irq_status;
    logic               mapped;
    logic [N-1:0]       clr_mask;

    assign evt.level = gpio_bank3_in;

    pww_edge_detect #(
        .N (N)
    ) u_edge (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .evt        (evt)
    );

    // register decode
    always_comb begin
        wr_status_g3  = wr_en_in && hit(addr_in, OFS_STATUS_G3);
        wr_enable_g1  = wr_en_in && hit(addr_in, OFS_ENABLE_G1);
        wr_master     = wr_en_in && hit(addr_in, OFS_MASTER_EN);
        wr_irq_mask   = wr_en_in && hit(addr_in, OFS_IRQ_MASK);
        rd_irq_status = rd_en_in && hit(addr_in, OFS_IRQ_STATUS);
        mapped        = hit(addr_in, OFS_STATUS_G3)
                     || hit(addr_in, OFS_ENABLE_G1)
                     || hit(addr_in, OFS_MASTER_EN)
                     || hit(addr_in, OFS_IRQ_STATUS)
                     || hit(addr_in, OFS_IRQ_MASK);
    end

    // write-one-to-clear; a zero bit leaves its status alone
    always_comb begin
        clr_mask = '0;
        if (wr_status_g3) begin
            clr_mask = wr_data_in[N-1:0];
        end
    end

    // set beats clear so an edge in the clearing cycle is kept;
    // no enable term enters here on purpose
    always_comb begin
        status_g3_nxt = (status_g3_r & ~clr_mask)
                      | evt.pulse;
    end

    // only the standby reset touches the status bits
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_g3_r <= RST_STATUS_G3[N-1:0];
        end else if (ce_in) begin
            status_g3_r <= status_g3_nxt;
        end
    end

    // enable group one, plain read/write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_g1_r <= RST_ENABLE_G1[N-1:0];
        end else if (ce_in && wr_enable_g1) begin
            enable_g1_r <= wr_data_in[N-1:0];
        end
    end

    // master enable; upper bits of that byte are reserved
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            master_en_r <= RST_MASTER_EN;
        end else if (ce_in && wr_master) begin
            master_en_r <= wr_data_in[MASTER_EN_BIT];
        end
    end

    // bank-1 status comes from the neighbouring group, bank-3 enables
    // likewise; the request is a level, so it drops as soon as the last
    // enabled set bit is cleared or disabled
    always_comb begin
        wake_nxt = master_en_r
                && (any_active(status_group_one_in, enable_g1_r)
                 || any_active(status_g3_r, enable_group_three_in));
    end

    // registered so the pin never glitches on decode changes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_r <= 1'b0;
        end else if (ce_in) begin
            wake_r <= wake_nxt;
        end
    end

    assign wake_request_out_n = ~wake_r;

    // interrupt events: request rising, new latch, unmapped access
    always_comb begin
        irq_event                = '0;
        irq_event[IRQ_WAKE_RISE] = wake_nxt && !wake_r;
        irq_event[IRQ_NEW_LATCH] = |(evt.pulse & ~status_g3_r);
        irq_event[IRQ_BAD_ADDR]  = (wr_en_in || rd_en_in) && !mapped;
    end

    // read clears, but an event in the same cycle survives
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (rd_irq_status) begin
            irq_status_nxt = '0;
        end
        irq_status_nxt = irq_status_nxt | irq_event;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_status_r <= RST_IRQ_STATUS;
        end else if (ce_in) begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask_r <= RST_IRQ_MASK;
        end else if (ce_in && wr_irq_mask) begin
            irq_mask_r <= wr_data_in[IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_status_r & irq_mask_r);

    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rd_data_nxt = RD_ZERO;
        if (rd_en_in) begin
            case (1'b1)
                hit(addr_in, OFS_STATUS_G3): begin
                    rd_data_nxt = to_byte(status_g3_r);
                end
                hit(addr_in, OFS_ENABLE_G1): begin
                    rd_data_nxt = to_byte(enable_g1_r);
                end
                hit(addr_in, OFS_MASTER_EN): begin
                    rd_data_nxt[MASTER_EN_BIT] = master_en_r;
                end
                hit(addr_in, OFS_IRQ_STATUS): begin
                    rd_data_nxt[IRQ_W-1:0] = irq_status_r;
                end
                hit(addr_in, OFS_IRQ_MASK): begin
                    rd_data_nxt[IRQ_W-1:0] = irq_mask_r;
                end
                default: begin
                    rd_data_nxt = RD_ZERO;
                end
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_r <= RD_ZERO;
        end else if (ce_in) begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_out            = rd_data_r;
    assign status_group_three_out = status_g3_r;

endmodule
`default_nettype wire

// ### test/pww_gpio_model.sv
// bank-3 wake input pins driven toward the block
// assumes pins are synchronous to the block clock
`timescale 1ns/1ps
`default_nettype none
module pww_gpio_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] level_in,
    output logic      [7:0] gpio_out
);
    // pins move only just after an edge, never between
    always_ff @(posedge clk_in) begin
        gpio_out <= level_in;
    end
endmodule
`default_nettype wire

// ### test/pww_wake_sva.sv
// assertions on the wake status and enable block ports
// assumes one clock and the standby reset, active low
`timescale 1ns/1ps
`default_nettype none
module pww_wake_sva
    import pww_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] gpio_bank3_in,
    input  wire logic [7:0] status_group_one_in,
    input  wire logic [7:0] enable_group_three_in,
    input  wire logic [7:0] rd_data_out,
    input  wire logic [7:0] status_group_three_out,
    input  wire logic       wake_request_out_n,
    input  wire logic       irq_out
);
    // shadows of registers the ports cannot show
    logic [7:0] g_q;
    logic [7:0] en1_r;
    logic       m_r;
    logic [7:0] rise;
    logic       wr_s;
    assign rise = gpio_bank3_in & ~g_q;
    assign wr_s = ce_in && wr_en_in && addr_in == OFS_STATUS_G3;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            g_q <= 8'h00;
        end else if (ce_in) begin
            g_q <= gpio_bank3_in;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en1_r <= 8'h00;
            m_r <= 1'b0;
        end else if (ce_in && wr_en_in) begin
            if (addr_in == OFS_ENABLE_G1) en1_r <= wr_data_in;
            if (addr_in == OFS_MASTER_EN) m_r <= wr_data_in[0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_rd_idle;
        ce_in && !rd_en_in |=> rd_data_out == RD_ZERO;
    endproperty
    property p_rd_sts;
        ce_in && rd_en_in && addr_in == OFS_STATUS_G3
            |=> rd_data_out == $past(status_group_three_out);
    endproperty
    property p_rd_en1;
        ce_in && rd_en_in && addr_in == OFS_ENABLE_G1
            |=> rd_data_out == $past(en1_r);
    endproperty
    property p_rd_mst;
        ce_in && rd_en_in && addr_in == OFS_MASTER_EN
            |=> rd_data_out[0] == $past(m_r);
    endproperty
    property p_set;
        ce_in && rise != 8'h00
            |=> (status_group_three_out & $past(rise)) == $past(rise);
    endproperty
    // bits with a fresh input rise may be set again by the same edge
    property p_w1c;
        wr_s |=> (status_group_three_out & $past(wr_data_in)
            & ~$past(gpio_bank3_in) & ~$past(gpio_bank3_in, 2)) == 8'h00;
    endproperty
    property p_keep;
        1 |=> ($past(status_group_three_out) & ~status_group_three_out
            & ~$past(wr_s ? wr_data_in : 8'h00)) == 8'h00;
    endproperty
    property p_wake;
        ce_in |=> wake_request_out_n == !$past(m_r && ((status_group_three_out
            & enable_group_three_in) | (status_group_one_in & en1_r)) != 0);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_rd_sts: assert property (p_rd_sts)
        else $error("status read wrong");
    a_rd_en1: assert property (p_rd_en1)
        else $error("enable read wrong");
    a_rd_mst: assert property (p_rd_mst)
        else $error("master read wrong");
    a_set: assert property (p_set)
        else $error("event not latched");
    a_w1c: assert property (p_w1c)
        else $error("status not cleared");
    a_keep: assert property (p_keep)
        else $error("status lost");
    a_wake: assert property (p_wake)
        else $error("wake wrong");
    c_wake: cover property ($fell(wake_request_out_n));
    c_irq: cover property ($rose(irq_out));
    c_clr: cover property (wr_s && wr_data_in != 8'h00);
endmodule
bind pww_wake_top pww_wake_sva i_sva (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .gpio_bank3_in(gpio_bank3_in), .status_group_one_in(status_group_one_in),
    .enable_group_three_in(enable_group_three_in), .rd_data_out(rd_data_out),
    .status_group_three_out(status_group_three_out),
    .wake_request_out_n(wake_request_out_n), .irq_out(irq_out));
`default_nettype wire

// ### test/tb_pww_wake_top.sv
// self-checking bench for the wake status and enable block
// assumes the gpio model and the bound checker alongside
`timescale 1ns/1ps
`default_nettype none
module tb_pww_wake_top;
    import pww_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ce = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] lvl = 8'h00;
    logic [7:0] s1 = 8'h00;
    logic [7:0] en3 = 8'h00;
    logic [7:0] gpio;
    logic [7:0] rdat;
    logic [7:0] sts;
    logic       wake_n;
    logic       irq;
    int         errors = 0;
    int         n_checks = 0;
    always #2.5 clk = ~clk;
    pww_gpio_model i_gpio (.clk_in(clk), .level_in(lvl), .gpio_out(gpio));
    pww_wake_top i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(ce),
        .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .gpio_bank3_in(gpio), .status_group_one_in(s1),
        .enable_group_three_in(en3), .rd_data_out(rdat),
        .status_group_three_out(sts), .wake_request_out_n(wake_n),
        .irq_out(irq));
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(nm, e, rdat);
    endtask
    // bounded wait; a hang ends the run at once
    task automatic wait_wake(input logic e);
        // step off the edge so the first look sees settled outputs
        #1;
        for (int i = 0; i < 8 && wake_n !== e; i++) @(posedge clk) #1;
        chk("wake", {7'h0, e}, {7'h0, wake_n});
        if (wake_n !== e) stop_test();
    endtask
    task automatic t_reset();
        rd("sts", OFS_STATUS_G3, 8'h00);
        rd("en1", OFS_ENABLE_G1, 8'h00);
        rd("mst", OFS_MASTER_EN, 8'h00);
        wait_wake(1'b1);
    endtask
    task automatic t_status();
        wr(OFS_MASTER_EN, 8'h01);
        lvl <= 8'h88;
        repeat (4) @(posedge clk);
        rd("sts", OFS_STATUS_G3, 8'h88);
        chk("sts_out", 8'h88, sts);
        wait_wake(1'b1);
        wr(OFS_STATUS_G3, 8'h77);
        rd("sts", OFS_STATUS_G3, 8'h88);
        wr(OFS_STATUS_G3, 8'h08);
        rd("sts", OFS_STATUS_G3, 8'h80);
        wr(OFS_STATUS_G3, 8'h80);
        rd("sts", OFS_STATUS_G3, 8'h00);
    endtask
    task automatic t_wake();
        en3 <= 8'h01;
        lvl <= 8'h01;
        wait_wake(1'b0);
        wr(OFS_MASTER_EN, 8'h00);
        wait_wake(1'b1);
        wr(OFS_MASTER_EN, 8'h01);
        wait_wake(1'b0);
        wr(OFS_STATUS_G3, 8'h01);
        wait_wake(1'b1);
        wr(OFS_ENABLE_G1, 8'h80);
        rd("en1", OFS_ENABLE_G1, 8'h80);
        s1 <= 8'h80;
        wait_wake(1'b0);
        s1 <= 8'h7f;
        wait_wake(1'b1);
    endtask
    // interrupt: status read clears, mask gates, unmapped access flags
    task automatic t_irq();
        rd("irq", OFS_IRQ_STATUS, 8'h03);
        wr(OFS_IRQ_MASK, 8'h02);
        lvl <= 8'h03;
        repeat (4) @(posedge clk);
        #1 chk("irq", 8'h01, {7'h0, irq});
        rd("irq", OFS_IRQ_STATUS, 8'h02);
        chk("irq", 8'h00, {7'h0, irq});
        rd("bad", 8'h20, 8'h00);
        wr(OFS_IRQ_MASK, 8'h04);
        #1 chk("irq", 8'h01, {7'h0, irq});
        rd("irq", OFS_IRQ_STATUS, 8'h04);
    endtask
    // clock enable low: a write in that cycle must be ignored
    task automatic t_ce();
        ce <= 1'b0;
        wr(OFS_ENABLE_G1, 8'h55);
        ce <= 1'b1;
        rd("ce", OFS_ENABLE_G1, 8'h80);
    endtask
    task automatic t_rereset();
        lvl <= 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd("sts", OFS_STATUS_G3, 8'h00);
        rd("en1", OFS_ENABLE_G1, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_status();
        t_wake();
        t_irq();
        t_ce();
        t_rereset();
        stop_test();
    end
endmodule
`default_nettype wire
